// ===== verilog/mas_seq.v
// multi-address two-wire slave sequencer
`timescale 1ns/10ps
`include "mas_seq_consts.vh"
module mas_seq (
  // clock and reset
  input wire ref_clk_i,
  input wire reset_n_i,
  // clock line
  input wire scl_in_i,
  output wire scl_out_o,
  output reg scl_oe_n_o,
  // data line
  input wire sda_in_i,
  output wire sda_out_o,
  output reg sda_oe_n_o,
  // status to upper logic, stop flag clear from it
  output reg [7:0] rx_byte_buffer_o,
  output reg [7:0] comm_status_byte_o,
  output reg [7:0] byte_done_flag_o,
  output reg [7:0] stop_seen_flag_o,
  input wire stop_flag_clear_i,
  // received byte stream
  output wire rx_valid_o,
  input wire rx_ready_i,
  output wire [7:0] rx_data_o,
  // strobes from upper logic
  input wire resume_receive_i,
  input wire resume_transmit_i,
  input wire [7:0] tx_byte_i,
  input wire end_transmit_i
);
  localparam S_IDLE = 5'd0;
  localparam S_START = 5'd1;
  localparam S_ADDR = 5'd2;
  localparam S_ACKW = 5'd3;
  localparam S_ACK = 5'd4;
  localparam S_NOSEL = 5'd5;
  localparam S_RXF = 5'd6;
  localparam S_RXB = 5'd7;
  localparam S_RXAW = 5'd8;
  localparam S_RXA = 5'd9;
  localparam S_RXH = 5'd10;
  localparam S_TXH = 5'd11;
  localparam S_TXS = 5'd12;
  localparam S_TXB = 5'd13;
  localparam S_TXA = 5'd14;
  localparam S_TXAF = 5'd15;
  localparam S_TXN = 5'd16;
  localparam S_TXE = 5'd17;
  localparam S_ACHK = 5'd18;

  // synchronisers and edge finding
  reg [1:0] scl_sync_q;
  reg [1:0] sda_sync_q;
  reg scl_prev_q;
  reg sda_prev_q;
  reg scl_rise_q;
  reg scl_fall_q;
  reg start_q;
  reg stop_q;
  reg [1:0] snap_q;
  wire scl_s;
  wire sda_s;
  wire scl_rise;
  wire scl_fall;

  // sequencer state
  reg [4:0] state_q;
  reg [3:0] cnt_q;
  reg [7:0] shift_q;
  reg [7:0] tx_sh_q;
  reg pend_q;
  reg [7:0] id_val;
  reg [7:0] ack_val;
  wire data_win;
  wire fifo_ready;
  wire fifo_push;

  assign scl_out_o = 1'b0;
  assign sda_out_o = 1'b0;
  assign scl_s = scl_sync_q[1];
  assign sda_s = sda_sync_q[1];
  assign scl_rise = scl_s & ~scl_prev_q;
  assign scl_fall = ~scl_s & scl_prev_q;

  // address table lookup on upper seven bits
  always @* begin
    case (shift_q[7:1])
      `MAS_ADR_A: id_val = `MAS_ID_A;
      `MAS_ADR_B: id_val = `MAS_ID_B;
      `MAS_ADR_C: id_val = `MAS_ID_C;
      `MAS_ADR_D: id_val = `MAS_ID_D;
      default: id_val = `MAS_UNSEL;
    endcase
  end

  // acknowledge enable per address id
  always @* begin
    case (id_val[7:4])
      4'h1: ack_val = `MAS_ACK_ON;
      4'h2: ack_val = `MAS_ACK_ON;
      4'h3: ack_val = `MAS_ACK_ON;
      4'h4: ack_val = `MAS_ACK_ON;
      default: ack_val = `MAS_ACK_OFF;
    endcase
  end

  // start and stop conditions count only in these states
  assign data_win = (state_q == S_IDLE) || (state_q == S_START) ||
                    (state_q == S_RXF);

  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      scl_sync_q <= 2'b11;
      sda_sync_q <= 2'b11;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_sync_q <= {scl_sync_q[0], scl_in_i};
      sda_sync_q <= {sda_sync_q[0], sda_in_i};
      scl_prev_q <= scl_s;
      sda_prev_q <= sda_s;
    end
  end

  // event stage with level snapshot
  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      scl_rise_q <= 1'b0;
      scl_fall_q <= 1'b0;
      start_q <= 1'b0;
      stop_q <= 1'b0;
      snap_q <= 2'b11;
    end else begin
      scl_rise_q <= scl_rise;
      scl_fall_q <= scl_fall;
      start_q <= data_win & ~sda_s & sda_prev_q & scl_s & scl_prev_q;
      stop_q <= data_win & sda_s & ~sda_prev_q & scl_s & scl_prev_q;
      if (scl_rise || scl_fall || (sda_s != sda_prev_q)) begin
        snap_q <= {scl_s, sda_s};
      end
    end
  end

  mas_fifo #(
    .W(`MAS_FIFO_WIDTH),
    .D(`MAS_FIFO_DEPTH),
    .AW(`MAS_FIFO_AW)
  ) u_fifo (
    .ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i),
    .in_valid_i(pend_q),
    .in_ready_o(fifo_ready),
    .in_data_i(rx_byte_buffer_o),
    .out_valid_o(rx_valid_o),
    .out_ready_i(rx_ready_i),
    .out_data_o(rx_data_o)
  );
  assign fifo_push = pend_q & fifo_ready;

  // stop flag, set beats clear
  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      stop_seen_flag_o <= `MAS_FLAG_CLR;
    end else if (stop_q) begin
      stop_seen_flag_o <= `MAS_FLAG_SET;
    end else if (stop_flag_clear_i) begin
      stop_seen_flag_o <= `MAS_FLAG_CLR;
    end
  end

  // main sequencer
  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= S_IDLE;
      cnt_q <= 4'h0;
      shift_q <= 8'h00;
      tx_sh_q <= 8'h00;
      pend_q <= 1'b0;
      scl_oe_n_o <= 1'b1;
      sda_oe_n_o <= 1'b1;
      rx_byte_buffer_o <= 8'h00;
      comm_status_byte_o <= 8'h00;
      byte_done_flag_o <= `MAS_FLAG_CLR;
    end else begin
      if (fifo_push) begin
        pend_q <= 1'b0;
      end
      if (start_q) begin
        state_q <= S_START;
        sda_oe_n_o <= 1'b1;
        comm_status_byte_o[`MAS_ST_STD] <= 1'b1;
        comm_status_byte_o[`MAS_ST_SPD] <= 1'b0;
      end else if (stop_q) begin
        state_q <= S_IDLE;
        sda_oe_n_o <= 1'b1;
        comm_status_byte_o[`MAS_ST_SPD] <= 1'b1;
        comm_status_byte_o[`MAS_ST_STD] <= 1'b0;
      end else begin
        case (state_q)
          S_IDLE: begin
            cnt_q <= 4'h0;
          end
          S_START: begin
            if (scl_fall_q) begin
              state_q <= S_ADDR;
              cnt_q <= 4'h0;
            end
          end
          S_ADDR: begin
            if (scl_rise_q) begin
              shift_q <= {shift_q[6:0], snap_q[0]};
              cnt_q <= cnt_q + 4'h1;
              if (cnt_q == `MAS_BIT_LAST) begin
                state_q <= S_ACHK;
              end
            end
          end
          S_ACHK: begin
            if (ack_val == `MAS_ACK_ON) begin
              state_q <= S_ACKW;
              comm_status_byte_o[7:4] <= id_val[7:4];
              comm_status_byte_o[`MAS_ST_TRC] <= shift_q[0];
            end else begin
              state_q <= S_NOSEL;
            end
          end
          S_ACKW: begin
            if (scl_fall_q) begin
              sda_oe_n_o <= 1'b0;
              state_q <= S_ACK;
            end
          end
          S_ACK: begin
            if (scl_fall_q) begin
              sda_oe_n_o <= 1'b1;
              if (comm_status_byte_o[`MAS_ST_TRC]) begin
                scl_oe_n_o <= 1'b0;
                byte_done_flag_o <= `MAS_FLAG_SET;
                state_q <= S_TXH;
              end else begin
                state_q <= S_RXF;
              end
            end
          end
          S_NOSEL: begin
            if (scl_rise_q && cnt_q == `MAS_BIT_NINTH) begin
              state_q <= S_IDLE;
            end
          end
          S_RXF: begin
            if (scl_rise_q) begin
              shift_q <= {shift_q[6:0], snap_q[0]};
              cnt_q <= 4'h1;
            end else if (scl_fall_q) begin
              state_q <= S_RXB;
            end
          end
          S_RXB: begin
            if (scl_rise_q) begin
              shift_q <= {shift_q[6:0], snap_q[0]};
              cnt_q <= cnt_q + 4'h1;
              if (cnt_q == `MAS_BIT_LAST) begin
                state_q <= S_RXAW;
              end
            end
          end
          S_RXAW: begin
            if (scl_fall_q) begin
              sda_oe_n_o <= 1'b0;
              state_q <= S_RXA;
            end
          end
          S_RXA: begin
            if (scl_fall_q) begin
              sda_oe_n_o <= 1'b1;
              scl_oe_n_o <= 1'b0;
              rx_byte_buffer_o <= shift_q;
              pend_q <= 1'b1;
              comm_status_byte_o[`MAS_ST_TRC] <= 1'b0;
              byte_done_flag_o <= `MAS_FLAG_SET;
              state_q <= S_RXH;
            end
          end
          S_RXH: begin
            if (resume_receive_i) begin
              scl_oe_n_o <= 1'b1;
              byte_done_flag_o <= `MAS_FLAG_CLR;
              state_q <= S_RXF;
            end
          end
          S_TXH: begin
            if (resume_transmit_i) begin
              tx_sh_q <= tx_byte_i;
              sda_oe_n_o <= tx_byte_i[7];
              byte_done_flag_o <= `MAS_FLAG_CLR;
              state_q <= S_TXS;
            end
          end
          S_TXS: begin
            scl_oe_n_o <= 1'b1;
            cnt_q <= 4'h0;
            state_q <= S_TXB;
          end
          S_TXB: begin
            if (scl_rise_q && cnt_q == 4'h0) begin
              comm_status_byte_o[2:0] <= 3'b000;
            end
            if (scl_fall_q) begin
              cnt_q <= cnt_q + 4'h1;
              if (cnt_q == `MAS_BIT_LAST) begin
                sda_oe_n_o <= 1'b1;
                state_q <= S_TXA;
              end else begin
                tx_sh_q <= {tx_sh_q[6:0], 1'b1};
                sda_oe_n_o <= tx_sh_q[6];
              end
            end
          end
          S_TXA: begin
            if (scl_rise_q) begin
              if (!snap_q[0]) begin
                comm_status_byte_o[`MAS_ST_ACK_SEEN_BIT] <= 1'b1;
                state_q <= S_TXAF;
              end else begin
                comm_status_byte_o[`MAS_ST_ACK_SEEN_BIT] <= 1'b0;
                state_q <= S_TXN;
              end
            end
          end
          S_TXAF: begin
            if (scl_fall_q) begin
              scl_oe_n_o <= 1'b0;
              byte_done_flag_o <= `MAS_FLAG_SET;
              state_q <= S_TXH;
            end
          end
          S_TXN: begin
            if (scl_fall_q) begin
              scl_oe_n_o <= 1'b0;
              byte_done_flag_o <= `MAS_FLAG_SET;
              state_q <= S_TXE;
            end
          end
          S_TXE: begin
            if (end_transmit_i) begin
              comm_status_byte_o <= 8'h00;
              byte_done_flag_o <= `MAS_FLAG_CLR;
              scl_oe_n_o <= 1'b1;
              sda_oe_n_o <= 1'b1;
              state_q <= S_IDLE;
            end
          end
          default: begin
            state_q <= S_IDLE;
          end
        endcase
      end
    end
  end
endmodule

// ===== verilog/mas_seq_consts.vh
// constants for the multi-address two-wire slave sequencer
`ifndef MAS_SEQ_CONSTS_VH
`define MAS_SEQ_CONSTS_VH
`define MAS_SYNC_STAGES 2
`define MAS_FIFO_WIDTH 8
`define MAS_FIFO_DEPTH 8
`define MAS_FIFO_AW 3
`define MAS_FLAG_SET 8'h01
`define MAS_FLAG_CLR 8'h00
`define MAS_ACK_ON 8'h0F
`define MAS_ACK_OFF 8'h00
`define MAS_UNSEL 8'h00
`define MAS_ADR_A 7'h30
`define MAS_ADR_B 7'h38
`define MAS_ADR_C 7'h40
`define MAS_ADR_D 7'h48
`define MAS_ID_A 8'h10
`define MAS_ID_B 8'h20
`define MAS_ID_C 8'h30
`define MAS_ID_D 8'h40
`define MAS_ST_TRC 3
`define MAS_ST_ACK_SEEN_BIT 2
`define MAS_ST_STD 1
`define MAS_ST_SPD 0
`define MAS_BIT_LAST 4'h7
`define MAS_BIT_NINTH 4'h8
`endif

// ===== verilog/mas_fifo.v
// byte fifo between the receive path and the upper logic
`timescale 1ns/10ps
module mas_fifo #(
  parameter W = 8,
  parameter D = 8,
  parameter AW = 3
) (
  // clock and reset
  input wire ref_clk_i,
  input wire reset_n_i,
  // fill side
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [W-1:0] in_data_i,
  // drain side
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [W-1:0] out_data_o
);
  reg [W-1:0] mem [0:D-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0] cnt_q;
  wire push;
  wire pop;
  assign in_ready_o = (cnt_q != D[AW:0]);
  assign out_valid_o = (cnt_q != {(AW+1){1'b0}});
  assign out_data_o = mem[rd_q];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;
  always @(posedge ref_clk_i) begin
    if (push) begin
      mem[wr_q] <= in_data_i;
    end
  end
  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= (wr_q == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule

// ===== verification/mas_seq_properties.sv
// port checks for the slave sequencer
`timescale 1ns/10ps
module mas_seq_properties (
  // clock and reset
  input wire ref_clk_i,
  input wire reset_n_i,
  // lines
  input wire scl_in_i,
  input wire scl_out_o,
  input wire scl_oe_n_o,
  input wire sda_out_o,
  input wire sda_oe_n_o,
  // upper side
  input wire [7:0] comm_status_byte_o,
  input wire [7:0] byte_done_flag_o,
  input wire [7:0] stop_seen_flag_o,
  input wire stop_flag_clear_i,
  input wire resume_receive_i,
  input wire end_transmit_i
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  a_scl_pull_only: assert property (!scl_oe_n_o |-> !scl_out_o)
    else $error("clock line driven high");
  a_sda_pull_only: assert property (!sda_oe_n_o |-> !sda_out_o)
    else $error("data line driven high");
  a_stop_sticky: assert property (stop_seen_flag_o == 8'h01 && !stop_flag_clear_i |=> stop_seen_flag_o == 8'h01)
    else $error("stop flag lost");
  a_stop_clk_high: assert property ($rose(stop_seen_flag_o[0]) |-> scl_in_i)
    else $error("stop seen with clock low");
  a_done_holds: assert property ($rose(byte_done_flag_o[0]) |-> ##[0:3] !scl_oe_n_o)
    else $error("done without clock hold");
  a_done_id: assert property ($rose(byte_done_flag_o[0]) |-> ##[0:3] (comm_status_byte_o[7:4] != 4'h0 && comm_status_byte_o[7:4] < 4'h5))
    else $error("bad address id");
  a_resume_frees: assert property (resume_receive_i && !scl_oe_n_o |-> ##[1:8] scl_oe_n_o)
    else $error("clock not released");
  a_end_frees: assert property (end_transmit_i |-> ##[1:8] (scl_oe_n_o && sda_oe_n_o))
    else $error("bus not released");
endmodule
bind mas_seq mas_seq_properties i_props (.*);

// ===== verification/mas_mst.sv
// two-wire bus master model
`timescale 1ns/10ps
module mas_mst (
  // wired levels
  input wire scl_i,
  input wire sda_i,
  // pulls, high is released
  output reg scl_o = 1'h1,
  output reg sda_o = 1'h1
);
  // one bit, clock stretched by the slave
  task bt(input b, output r);
    sda_o = b;
    #200 scl_o = 1'h1;
    wait (scl_i) #200 r = sda_i;
    #200 scl_o = 1'h0;
    #200;
  endtask
  task xb(input [7:0] d, input a, output [7:0] q, output k);
    for (int n = 7; n >= 0; n--)
      bt(d[n], q[n]);
    bt(a, k);
  endtask
  task start;
    sda_o = 1'h1;
    scl_o = 1'h1;
    wait (scl_i) #400 sda_o = 1'h0;
    #400 scl_o = 1'h0;
    #200;
  endtask
  task stop;
    sda_o = 1'h0;
    #200 scl_o = 1'h1;
    wait (scl_i) #400 sda_o = 1'h1;
    #400;
  endtask
endmodule

// ===== verification/mas_seq_tb.sv
// testbench for the slave sequencer
`timescale 1ns/10ps
module mas_seq_tb;
  reg ref_clk_i = 0;
  reg reset_n_i, rx_ready_i, stop_flag_clear_i;
  reg resume_receive_i, resume_transmit_i, end_transmit_i, k;
  reg [7:0] tx_byte_i, q, d;
  wire m_scl, m_sda, scl_out_o, scl_oe_n_o, sda_out_o, sda_oe_n_o, rx_valid_o;
  wire [7:0] rx_byte_buffer_o, comm_status_byte_o, byte_done_flag_o;
  wire [7:0] stop_seen_flag_o, rx_data_o;
  wire scl = m_scl & (scl_oe_n_o | scl_out_o);
  wire sda = m_sda & (sda_oe_n_o | sda_out_o);
  integer n_mismatch = 0, tests_run = 0, i, j;
  mas_seq i_dut (.*, .scl_in_i(scl), .sda_in_i(sda));
  mas_mst i_mst (.scl_i(scl), .sda_i(sda), .scl_o(m_scl), .sda_o(m_sda));
  initial forever #50 ref_clk_i = ~ref_clk_i;
  task chk(input string nm, input [8:0] got, input [8:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask
  // strobe: 0 resume rx, 1 resume tx, 2 end tx, 3 clear stop
  task pulse(input [1:0] s);
    @(negedge ref_clk_i) {stop_flag_clear_i, end_transmit_i, resume_transmit_i,
      resume_receive_i} = 4'h1 << s;
    @(negedge ref_clk_i) {stop_flag_clear_i, end_transmit_i, resume_transmit_i,
      resume_receive_i} = 4'h0;
  endtask
  // wait for clock hold with done flag
  task hold;
    for (j = 0; j < 50 && (scl_oe_n_o !== 0 || byte_done_flag_o !== 8'h01); j++)
      @(negedge ref_clk_i);
  endtask
  task results;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // watchdog, about twenty times the expected run
  initial begin
    #2000000;
    n_mismatch++;
    results;
  end
  initial begin
    reset_n_i = 0;
    {rx_ready_i, resume_receive_i, resume_transmit_i, end_transmit_i} = 0;
    {stop_flag_clear_i, tx_byte_i} = 0;
    repeat (10) @(negedge ref_clk_i);
    reset_n_i = 1;
    i_mst.stop;
    chk("stop", stop_seen_flag_o, 8'h01);
    pulse(3);
    chk("clr", stop_seen_flag_o, 8'h00);
    i_mst.start;
    i_mst.xb(8'h62, 1, q, k);
    chk("nack", k, 1);
    i_mst.stop;
    pulse(3);
    d = 8'hA0;
    i_mst.start;
    i_mst.xb(8'h60, 1, q, k);
    chk("ack", k, 0);
    repeat (8) begin
      i_mst.xb(d, 1, q, k);
      hold;
      chk("done", byte_done_flag_o, 8'h01);
      chk("rx", rx_byte_buffer_o, d);
      chk("st", comm_status_byte_o[7:3], 5'h02);
      pulse(0);
      d = d + 8'h01;
    end
    i_mst.stop;
    chk("sp", stop_seen_flag_o, 8'h01);
    d = 8'hA0;
    repeat (8) begin
      chk("fifo", {rx_valid_o, rx_data_o}, {1'h1, d});
      @(negedge ref_clk_i) rx_ready_i = 1;
      @(negedge ref_clk_i) rx_ready_i = 0;
      d = d + 8'h01;
    end
    chk("empty", rx_valid_o, 0);
    i_mst.start;
    i_mst.xb(8'h71, 1, q, k);
    chk("ack", k, 0);
    hold;
    chk("st", comm_status_byte_o[7:3], 5'h05);
    for (i = 0; i < 2; i++) begin
      tx_byte_i = i ? 8'h3C : 8'hA5;
      pulse(1);
      i_mst.xb(8'hFF, i[0], q, k);
      chk("tx", q, tx_byte_i);
      hold;
      chk("done", byte_done_flag_o, 8'h01);
    end
    chk("ack_seen_bit", comm_status_byte_o[2], 0);
    pulse(2);
    repeat (8) @(negedge ref_clk_i);
    chk("free", {scl_oe_n_o, sda_oe_n_o}, 3);
    i_mst.stop;
    results;
  end
endmodule
